// ==== core/vsad_pkg.sv ====
package vsad_pkg;
    // address modifier codes
    localparam logic [5:0] AM_A24_SUP_BLT  = 6'h3F;
    localparam logic [5:0] AM_A24_SUP_DAT  = 6'h3D;
    localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
    localparam logic [5:0] AM_A24_USR_BLT  = 6'h3B;
    localparam logic [5:0] AM_A24_USR_DAT  = 6'h39;
    localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
    localparam logic [5:0] AM_CSR          = 6'h2F;
    localparam logic [5:0] AM_A32_SUP_BLT  = 6'h0F;
    localparam logic [5:0] AM_A32_SUP_DAT  = 6'h0D;
    localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
    localparam logic [5:0] AM_A32_USR_BLT  = 6'h0B;
    localparam logic [5:0] AM_A32_USR_DAT  = 6'h09;
    localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
    // control bit position and reset values
    localparam int         ADDR_SRC_BIT    = 4;
    localparam logic [7:0] CHAIN_ADDR_RST  = 8'hAA;
    // output buffer occupies offsets below this
    localparam logic [15:0] OUTBUF_END     = 16'h0800;
    // slot code position in header and end words
    localparam int          SLOT_MSB       = 31;
    localparam int          SLOT_LSB       = 27;
    // decode kinds
    typedef enum logic [2:0] {
        VSAD_NONE, VSAD_BASE, VSAD_GEO, VSAD_MCST, VSAD_CBLT
    } vsad_kind_t;
endpackage : vsad_pkg

// ==== core/vsad_if.sv ====
`timescale 1ns/1ps
// simplified synchronous vme-style cycle plus iack daisy chain
interface vsad_if;
    logic        as_n;       // address strobe, low while cycle active
    logic [31:0] addr;       // address lines
    logic [5:0]  am;         // address modifier
    logic        write_n;    // low for write
    logic        ds_n;       // data strobe, low per beat
    logic [31:0] wdata;      // write data
    logic [31:0] rdata;      // read data from slave
    logic        dtack_n;    // data acknowledge
    logic        berr_n;     // bus error
    logic        iackin_n;   // token in from previous board
    logic        iackout_n;  // token out to next board
    modport slave  (input as_n, addr, am, write_n, ds_n, wdata, iackin_n,
                    output rdata, dtack_n, berr_n, iackout_n);
    modport master (output as_n, addr, am, write_n, ds_n, wdata, iackin_n,
                    input rdata, dtack_n, berr_n, iackout_n);
endinterface : vsad_if

// ==== core/vsad_master.sv ====
`timescale 1ns/1ps
// bus master end: runs one cycle per request, one beat per ds
module vsad_master (
    input  wire logic        clk,
    input  wire logic        reset,
    vsad_if.master           bus,
    input  wire logic        req,
    input  wire logic [31:0] req_addr,
    input  wire logic [5:0]  req_am,
    input  wire logic        req_write,
    input  wire logic [31:0] req_wdata,
    input  wire logic [7:0]  req_beats,
    output logic             busy,
    output logic             done,
    output logic             err,
    output logic [31:0]      rd_data,
    output logic             rd_valid
);
    typedef enum logic [1:0] {M_IDLE, M_BEAT, M_GAP} vsad_mst_t;
    typedef struct packed {
        vsad_mst_t   st;
        logic [31:0] addr;
        logic [5:0]  am;
        logic        wr;
        logic [31:0] wd;
        logic [7:0]  left;
        logic        done;
        logic        err;
        logic [31:0] rd;
        logic        rv;
    } vsad_mst_state_t;
    vsad_mst_state_t s_reg, s_next;
    logic dtack_s1, dtack_s2, berr_s1, berr_s2; // pin synchronisers

    // synchronise slave answers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            dtack_s1 <= 1'b1;
            dtack_s2 <= 1'b1;
            berr_s1  <= 1'b1;
            berr_s2  <= 1'b1;
        end else begin
            dtack_s1 <= bus.dtack_n;
            dtack_s2 <= dtack_s1;
            berr_s1  <= bus.berr_n;
            berr_s2  <= berr_s1;
        end
    end

    // next state
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.rv = 1'b0;
        unique case (s_reg.st)
            M_IDLE: begin
                if (req) begin
                    s_next.st = M_BEAT;
                    s_next.addr = req_addr;
                    s_next.am = req_am;
                    s_next.wr = req_write;
                    s_next.wd = req_wdata;
                    s_next.left = (req_beats == 8'h00) ? 8'h01 : req_beats;
                    s_next.err = 1'b0;
                end
            end
            M_BEAT: begin
                // bus error ends the whole cycle, but the slave must let go first
                if (!berr_s2) begin
                    s_next.err = 1'b1;
                    s_next.left = 8'h00;
                    s_next.st = M_GAP;
                end else if (!dtack_s2) begin
                    s_next.rd = bus.rdata;
                    s_next.rv = !s_reg.wr;
                    s_next.left = s_reg.left - 8'h01;
                    s_next.st = M_GAP;
                end
            end
            M_GAP: begin
                // wait for slave to release before next beat
                if (dtack_s2 && berr_s2) begin
                    if (s_reg.left == 8'h00) begin
                        s_next.done = 1'b1;
                        s_next.st = M_IDLE;
                    end else begin
                        s_next.st = M_BEAT;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.as_n     = (s_reg.st == M_IDLE);
    assign bus.ds_n     = (s_reg.st != M_BEAT);
    assign bus.addr     = s_reg.addr;
    assign bus.am       = s_reg.am;
    assign bus.write_n  = !s_reg.wr;
    assign bus.wdata    = s_reg.wd;
    assign bus.iackin_n = (s_reg.st == M_IDLE);
    assign busy     = (s_reg.st != M_IDLE);
    assign done     = s_reg.done;
    assign err      = s_reg.err;
    assign rd_data  = s_reg.rd;
    assign rd_valid = s_reg.rv;
endmodule : vsad_master

// ==== core/vsad_slave.sv ====
`timescale 1ns/1ps
// Behaviour
// - base decode accepts listed a24/a32 codes
// - base compares a23..16 or a31..16
// - select bit clear uses rotary switches
// - select bit set uses relocation registers
// - geographic only a24 configuration code
// - geographic cannot reach output buffer
// - slot code captured after each reset
// - geo: a23..19 slot, a18..16 zero
// - no slot lines, no geographic decode
// - written slot tags data, never decodes
// - chain modes a32: blt chained, data multicast
// - multicast write taken by all chain boards
// - chained readout block read buffer only
// - chain byte a31..24, a23..16 zero
// - token on iack chain gates data
// - first/last flags encode chain role
// - master programs one first, one last
// - each chain has distinct address byte
// - slot code in top five bits
module vsad_slave #(
    parameter bit HAS_SLOT_LINES = 1'b1  // board carries aux backplane connector
) (
    input  wire logic        clk,
    input  wire logic        reset,
    vsad_if.slave            bus,
    input  wire logic [4:0]  slot_number_lines,   // backplane slot code pins
    input  wire logic [15:0] rotary_switch,       // a31..16 from switches
    input  wire logic        addr_src_sel,        // bit 4 of first set-bits register
    input  wire logic [7:0]  reloc_high,          // a31..24 relocation value
    input  wire logic [7:0]  reloc_low,           // a23..16 relocation value
    input  wire logic [7:0]  chain_addr,          // chain address byte
    input  wire logic        chain_first,         // first flag
    input  wire logic        chain_last,          // last flag
    input  wire logic        slot_wr,             // master writes slot register
    input  wire logic [4:0]  slot_wdata,          // value written
    input  wire logic [31:0] buf_data,            // output buffer word
    input  wire logic        buf_empty,           // no more board data
    input  wire logic        buf_mark,            // word is header or end word
    input  wire logic [31:0] reg_rdata,           // register read data
    output logic             acc_valid,           // one-cycle access pulse
    output logic             acc_write,           // access is write
    output logic [15:0]      acc_offset,          // register offset
    output logic [31:0]      acc_wdata,           // write data
    output vsad_pkg::vsad_kind_t acc_kind,        // how access decoded
    output logic             buf_pop,             // take next buffer word
    output logic [4:0]       geo_addr,            // effective slot code
    output logic [4:0]       tag_slot             // slot code for data tags
);
    typedef enum logic [1:0] {S_IDLE, S_ACK, S_WAIT} vsad_slv_t;
    typedef struct packed {
        vsad_slv_t            st;
        logic                 grab;     // slot capture pending after reset
        logic [4:0]           geo;      // latched slot code
        logic [4:0]           tag;      // slot register for tagging
        logic                 tok;      // token handed onward
        logic                 done;     // chained board finished its data
        logic [31:0]          rd;
        logic                 dtack;
        logic                 berr;
        logic                 av;
        logic                 aw;
        logic [15:0]          ao;
        logic [31:0]          awd;
        vsad_pkg::vsad_kind_t ak;
        logic                 pop;
    } vsad_slv_state_t;
    vsad_slv_state_t s_reg, s_next;
    // pin synchronisers, stage one read only by stage two
    logic [4:0] sn_s1, sn_s2;
    logic       as_s1, as_s2, ds_s1, ds_s2, ia_s1, ia_s2;

    // classify a base-address modifier
    function automatic logic base_am(input logic [5:0] m, output logic a32);
        a32 = (m[5:4] == 2'b00);
        unique case (m)
            vsad_pkg::AM_A24_SUP_BLT, vsad_pkg::AM_A24_SUP_DAT,
            vsad_pkg::AM_A24_SUP_MBLT, vsad_pkg::AM_A24_USR_BLT,
            vsad_pkg::AM_A24_USR_DAT, vsad_pkg::AM_A24_USR_MBLT,
            vsad_pkg::AM_A32_SUP_BLT, vsad_pkg::AM_A32_SUP_DAT,
            vsad_pkg::AM_A32_SUP_MBLT, vsad_pkg::AM_A32_USR_BLT,
            vsad_pkg::AM_A32_USR_DAT, vsad_pkg::AM_A32_USR_MBLT: base_am = 1'b1;
            default: base_am = 1'b0;
        endcase
    endfunction : base_am

    // slot lines keep sampling through reset, so the code is settled when grab reads it
    always_ff @(posedge clk) begin
        sn_s1 <= slot_number_lines;
        sn_s2 <= sn_s1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            as_s1 <= 1'b1;
            as_s2 <= 1'b1;
            ds_s1 <= 1'b1;
            ds_s2 <= 1'b1;
            ia_s1 <= 1'b1;
            ia_s2 <= 1'b1;
        end else begin
            as_s1 <= bus.as_n;
            as_s2 <= as_s1;
            ds_s1 <= bus.ds_n;
            ds_s2 <= ds_s1;
            ia_s1 <= bus.iackin_n;
            ia_s2 <= ia_s1;
        end
    end

    logic [15:0]          base_hi;   // selected base a31..16
    logic                 is_a32;
    logic                 am_ok;
    logic                 active;    // board in a chain
    logic                 has_tok;
    logic                 chain_hit;
    vsad_pkg::vsad_kind_t kind;

    // address decode
    always_comb begin
        is_a32 = 1'b0;
        am_ok = base_am(bus.am, is_a32);
        base_hi = rotary_switch;
        if (addr_src_sel) begin
            base_hi = {reloc_high, reloc_low};
        end
        active = chain_first | chain_last;
        has_tok = (chain_first && !chain_last) || !ia_s2;
        chain_hit = (bus.addr[31:24] == chain_addr) && (bus.addr[23:16] == 8'h00);
        kind = vsad_pkg::VSAD_NONE;
        // chain codes decoded in a32 only
        if (chain_hit && active && !bus.write_n &&
            (bus.am == vsad_pkg::AM_A32_SUP_DAT || bus.am == vsad_pkg::AM_A32_USR_DAT)) begin
            kind = vsad_pkg::VSAD_MCST;
        end else if (chain_hit && active && bus.write_n &&
                     (bus.am == vsad_pkg::AM_A32_SUP_BLT ||
                      bus.am == vsad_pkg::AM_A32_USR_BLT ||
                      bus.am == vsad_pkg::AM_A32_SUP_MBLT ||
                      bus.am == vsad_pkg::AM_A32_USR_MBLT) &&
                     bus.addr[15:0] < vsad_pkg::OUTBUF_END) begin
            kind = vsad_pkg::VSAD_CBLT;
        end else if (HAS_SLOT_LINES && bus.am == vsad_pkg::AM_CSR &&
                     bus.addr[23:19] == s_reg.geo && bus.addr[18:16] == 3'h0 &&
                     bus.addr[15:0] >= vsad_pkg::OUTBUF_END) begin
            kind = vsad_pkg::VSAD_GEO;
        end else if (am_ok && ((is_a32 && bus.addr[31:16] == base_hi) ||
                               (!is_a32 && bus.addr[23:16] == base_hi[7:0]))) begin
            kind = vsad_pkg::VSAD_BASE;
        end
    end

    // cycle sequencing
    always_comb begin
        s_next = s_reg;
        s_next.av = 1'b0;
        s_next.pop = 1'b0;
        // capture slot code after reset release
        if (s_reg.grab) begin
            s_next.grab = 1'b0;
            s_next.geo = sn_s2;
            s_next.tag = sn_s2;
        end
        if (slot_wr && !HAS_SLOT_LINES) begin
            s_next.tag = slot_wdata;
        end
        if (as_s2) begin
            // cycle over, token and done state reset
            s_next.tok = 1'b0;
            s_next.done = 1'b0;
        end
        unique case (s_reg.st)
            S_IDLE: begin
                if (!as_s2 && !ds_s2 && kind != vsad_pkg::VSAD_NONE) begin
                    s_next.ak = kind;
                    s_next.ao = bus.addr[15:0];
                    s_next.aw = !bus.write_n;
                    s_next.awd = bus.wdata;
                    if (kind == vsad_pkg::VSAD_CBLT) begin
                        if (!has_tok || s_reg.done) begin
                            // pass token on only when holder already done
                            s_next.tok = has_tok;
                        end else if (buf_empty) begin
                            s_next.done = 1'b1;
                            // last board ends with bus error
                            if (chain_last && !chain_first) begin
                                s_next.berr = 1'b1;
                                s_next.st = S_WAIT;
                            end else begin
                                s_next.tok = 1'b1;
                            end
                        end else begin
                            s_next.rd = buf_data;
                            if (buf_mark) begin
                                s_next.rd[vsad_pkg::SLOT_MSB:vsad_pkg::SLOT_LSB] = s_reg.tag;
                            end
                            s_next.pop = 1'b1;
                            s_next.av = 1'b1;
                            s_next.st = S_ACK;
                        end
                    end else begin
                        s_next.rd = reg_rdata;
                        s_next.av = 1'b1;
                        s_next.st = S_ACK;
                    end
                end
            end
            S_ACK: begin
                // multicast answered by last board only, others stay silent
                s_next.dtack = !(s_reg.ak == vsad_pkg::VSAD_MCST) || (chain_last && !chain_first);
                s_next.st = S_WAIT;
            end
            S_WAIT: begin
                if (ds_s2) begin
                    s_next.dtack = 1'b0;
                    s_next.berr = 1'b0;
                    s_next.st = S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s_reg <= '0;
            s_reg.grab <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign bus.rdata     = s_reg.rd;
    assign bus.dtack_n   = !s_reg.dtack;
    assign bus.berr_n    = !s_reg.berr;
    assign bus.iackout_n = !s_reg.tok;
    assign acc_valid  = s_reg.av;
    assign acc_write  = s_reg.aw;
    assign acc_offset = s_reg.ao;
    assign acc_wdata  = s_reg.awd;
    assign acc_kind   = s_reg.ak;
    assign buf_pop    = s_reg.pop;
    assign geo_addr   = s_reg.geo;
    assign tag_slot   = s_reg.tag;
endmodule : vsad_slave

// ==== testbench/vsad_bus_sva.sv ====
`timescale 1ns/1ps
// watches the backplane wires between the two ends
module vsad_bus_sva (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        as_n,
    input wire logic [31:0] addr,
    input wire logic [5:0]  am,
    input wire logic        write_n,
    input wire logic        ds_n,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        dtack_n,
    input wire logic        berr_n,
    input wire logic        iackin_n,
    input wire logic        iackout_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    // strobes still low when the answer comes
    sequence s_strobes_low;
        !as_n && !ds_n;
    endsequence
    // answer held long enough for a synced master to see it
    sequence s_ack_held;
        (!dtack_n) [*3];
    endsequence

    a_ack_exclusive: assert property (!(!dtack_n && !berr_n))
        else $error("dtack and berr low together");
    a_ack_holds: assert property ($fell(dtack_n) |-> s_ack_held)
        else $error("dtack released too early");
    // two sync stages plus decode lie between strobe and answer
    a_ack_cause: assert property ($fell(dtack_n) |-> !$past(ds_n, 3) ##0 s_strobes_low)
        else $error("dtack without a held data strobe");
    a_am_known: assert property (($fell(dtack_n) || $fell(berr_n)) |-> am inside
        {6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38, 6'h2F,
         6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08})
        else $error("answer to an unknown modifier");
    a_geo_gap_zero: assert property ($fell(dtack_n) && am == 6'h2F |-> addr[18:16] == 3'h0)
        else $error("geographic answer with nonzero gap bits");
    a_geo_no_buffer: assert property ($fell(dtack_n) && am == 6'h2F |-> addr[15:0] >= 16'h0800)
        else $error("geographic answer inside output buffer");
    a_berr_chain_read: assert property ($fell(berr_n) |-> write_n && addr[23:16] == 8'h00
        && am inside {6'h0F, 6'h0C, 6'h0B, 6'h08})
        else $error("bus error outside a chained read");
    a_token_gated: assert property ($fell(iackout_n) |-> !as_n && !iackin_n)
        else $error("token passed outside a cycle");
    a_reset_quiet: assert property ($fell(reset) |-> dtack_n && berr_n && iackout_n)
        else $error("bus driven right after reset");
endmodule : vsad_bus_sva

// ==== testbench/test_vme_slave_address_decode.sv ====
`timescale 1ns/1ps
// drives the master's user side and the slave's board inputs, checks decode
module test_vme_slave_address_decode;
    logic        clk = 1'b0, reset = 1'b1, req = 1'b0, req_write = 1'b0;
    logic [31:0] req_addr = '0, req_wdata = '0, buf_data = '0, reg_rdata = '0;
    logic [5:0]  req_am = '0;
    logic [4:0]  slot = 5'h05, slot_wdata = '0, geo_exp = 5'h05;
    logic [15:0] rotary = 16'hEE00;             // a31..16 from switches
    logic [7:0]  reloc_high = 8'h5A, reloc_low = 8'h3C, chain_addr = 8'hAA;
    logic        src_sel = 1'b0, chain_first = 1'b0, chain_last = 1'b0, slot_wr = 1'b0;
    logic        buf_empty = 1'b0, buf_mark = 1'b0, got_acc = 1'b0;
    logic        busy, done, err, rd_valid, acc_valid, acc_write, buf_pop;
    logic [31:0] rd_data, acc_wdata;
    logic [15:0] acc_offset;
    logic [4:0]  geo_addr, tag_slot;
    vsad_pkg::vsad_kind_t acc_kind, exp_kind;   // kind seen and expected
    logic [31:0] exp_wdata;
    logic [15:0] exp_off;
    logic [31:0] rd_q[$];                       // reads still owed to the master
    int          n_errors = 0, num_checks = 0, cycles = 0;
    logic [5:0]  codes[12] = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38,
                               6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};

    vsad_if bus_if ();
    vsad_master vsad_master_i (.clk(clk), .reset(reset), .bus(bus_if), .req(req),
        .req_addr(req_addr), .req_am(req_am), .req_write(req_write), .req_wdata(req_wdata),
        .req_beats(8'h00), .busy(busy), .done(done), .err(err), .rd_data(rd_data),
        .rd_valid(rd_valid));
    vsad_slave vsad_slave_i (.clk(clk), .reset(reset), .bus(bus_if),
        .slot_number_lines(slot), .rotary_switch(rotary), .addr_src_sel(src_sel),
        .reloc_high(reloc_high), .reloc_low(reloc_low), .chain_addr(chain_addr),
        .chain_first(chain_first), .chain_last(chain_last), .slot_wr(slot_wr),
        .slot_wdata(slot_wdata), .buf_data(buf_data), .buf_empty(buf_empty),
        .buf_mark(buf_mark), .reg_rdata(reg_rdata), .acc_valid(acc_valid),
        .acc_write(acc_write), .acc_offset(acc_offset), .acc_wdata(acc_wdata),
        .acc_kind(acc_kind), .buf_pop(buf_pop), .geo_addr(geo_addr), .tag_slot(tag_slot));
    vsad_bus_sva vsad_bus_sva_i (.clk(clk), .reset(reset), .as_n(bus_if.as_n),
        .addr(bus_if.addr), .am(bus_if.am), .write_n(bus_if.write_n), .ds_n(bus_if.ds_n),
        .wdata(bus_if.wdata), .rdata(bus_if.rdata), .dtack_n(bus_if.dtack_n),
        .berr_n(bus_if.berr_n), .iackin_n(bus_if.iackin_n), .iackout_n(bus_if.iackout_n));

    // free-running clock
    always #2.5 clk = ~clk;

    // a hung cycle must not stall the run forever
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_errors++;
            summarize();
        end
    end

    // compare each access pulse and each read beat as it arrives
    always @(posedge clk) begin
        if (acc_valid === 1'b1) begin
            got_acc = 1'b1;
            check("kind", 32'(acc_kind), 32'(exp_kind));
            check("offset", 32'(acc_offset), 32'(exp_off));
            check("write", {31'h0, acc_write}, {31'h0, req_write});
            check("pop", {31'h0, buf_pop}, {31'h0, exp_kind == vsad_pkg::VSAD_CBLT});
            if (acc_write === 1'b1) check("wdata", acc_wdata, exp_wdata);
        end
        if (rd_valid === 1'b1) check("rdata", rd_data,
            rd_q.size() > 0 ? rd_q.pop_front() : 32'hDEADBEEF);
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        if (n_errors == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize

    // slot lines settle well before release; latched code is the new geo address
    task automatic do_reset(input logic [4:0] s);
        slot = s;
        geo_exp = s;
        reset = 1'b1;
        repeat (12) @(negedge clk);
        reset = 1'b0;
        repeat (4) @(negedge clk);
    endtask : do_reset

    // reference decode written from the addressing rules
    function automatic vsad_pkg::vsad_kind_t model(input logic [31:0] a, input logic [5:0] m,
                                                   input logic w);
        logic [15:0] base;
        logic        a24_ok, a32_ok;
        base = src_sel ? {reloc_high, reloc_low} : rotary;
        {a24_ok, a32_ok} = 2'b00;
        for (int i = 0; i < 6; i++) begin
            a24_ok |= m == codes[i];
            a32_ok |= m == codes[i + 6];
        end
        // geographic only on the configuration code
        if (m == 6'h2F) return (a[23:19] == geo_exp && a[18:16] == 3'h0 && a[15:0] >= 16'h0800)
            ? vsad_pkg::VSAD_GEO : vsad_pkg::VSAD_NONE;
        // chain byte on top, zero byte below
        if (a32_ok && a[31:24] == chain_addr && a[23:16] == 8'h00) begin
            if (!(chain_first || chain_last)) return vsad_pkg::VSAD_NONE;
            if (m[1:0] == 2'b01) return w ? vsad_pkg::VSAD_MCST : vsad_pkg::VSAD_NONE;
            return w ? vsad_pkg::VSAD_NONE : vsad_pkg::VSAD_CBLT;
        end
        // a24 compares a23..16, a32 compares a31..16
        if (a24_ok) return a[23:16] == base[7:0] ? vsad_pkg::VSAD_BASE
            : vsad_pkg::VSAD_NONE;
        if (a32_ok) return a[31:16] == base ? vsad_pkg::VSAD_BASE
            : vsad_pkg::VSAD_NONE;
        return vsad_pkg::VSAD_NONE;
    endfunction : model

    // one single-beat cycle; a refused one hangs the master, so reset after it
    task automatic access(input logic [31:0] a, input logic [5:0] m, input logic w);
        int n;
        logic empty_end;
        n = 0;
        exp_kind = model(a, m, w);
        empty_end = exp_kind == vsad_pkg::VSAD_CBLT && buf_empty;
        exp_off = a[15:0];
        exp_wdata = $urandom;
        got_acc = 1'b0;
        if (!w && exp_kind != vsad_pkg::VSAD_NONE && !(exp_kind == vsad_pkg::VSAD_CBLT && buf_empty))
            rd_q.push_back(exp_kind != vsad_pkg::VSAD_CBLT ? reg_rdata
                : buf_mark ? {geo_exp, buf_data[26:0]} : buf_data);
        req = 1'b1;
        req_addr = a;
        req_am = m;
        req_write = w;
        req_wdata = exp_wdata;
        @(negedge clk);
        req = 1'b0;
        while (done !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        if (exp_kind == vsad_pkg::VSAD_NONE) begin
            check("answered", {31'h0, done}, 32'h0);
            check("accepted", {31'h0, got_acc}, 32'h0);
            do_reset(slot);
        end else begin
            check("done", {31'h0, done}, 32'h1);
            check("err", {31'h0, err}, {31'h0, empty_end});
            if (!(exp_kind == vsad_pkg::VSAD_CBLT && buf_empty))
                check("accepted", {31'h0, got_acc}, 32'h1);
            @(negedge clk);
        end
    endtask : access

    initial begin
        void'($urandom(32'h225FE03B));
        buf_data = $urandom;
        reg_rdata = $urandom;
        do_reset(5'h05);
        check("geo", 32'(geo_addr), 32'h05);
        // every base code through the switches; a24 ignores the top byte
        for (int i = 0; i < 12; i++)
            access(i < 6 ? {8'($urandom), rotary[7:0], 16'h1000 | 16'($urandom & 32'h7FE)}
                : {rotary, 16'h1000 | 16'($urandom & 32'h7FE)}, codes[i], 1'b1);
        access({rotary, 16'h100E}, 6'h09, 1'b0);
        access({rotary ^ 16'h0100, 16'h1000}, 6'h0D, 1'b1);
        access({rotary, 16'h1000}, 6'h3E, 1'b1);
        src_sel = 1'b1;
        access({rotary, 16'h1010}, 6'h0D, 1'b1);
        access({reloc_high, reloc_low, 16'h1010}, 6'h0D, 1'b1);
        access({8'h00, reloc_low, 16'h1012}, 6'h3D, 1'b1);
        src_sel = 1'b0;
        access({8'($urandom), 5'h05, 3'h0, 16'h1006}, 6'h2F, 1'b1);
        access({8'h00, 5'h05, 3'h2, 16'h1006}, 6'h2F, 1'b1);
        access({8'h00, 5'h05, 3'h0, 16'h0004}, 6'h2F, 1'b0);
        access({8'h00, 5'h05, 3'h0, 16'h1006}, 6'h3D, 1'b1);
        do_reset(5'h0B);
        check("geo", 32'(geo_addr), 32'h0B);
        slot_wr = 1'b1;
        slot_wdata = 5'h1F;
        @(negedge clk);
        slot_wr = 1'b0;
        repeat (3) @(negedge clk);
        check("geo", 32'(geo_addr), 32'h0B);
        check("tag", 32'(tag_slot), 32'h0B);
        // lone board of the chain is its only last
        // the one chain owns its address byte
        chain_last = 1'b1;
        access({chain_addr, 8'h00, 16'h1006}, 6'h09, 1'b1);
        access({chain_addr, 8'h00, 16'h1006}, 6'h0D, 1'b0);
        buf_mark = 1'b1;
        access({chain_addr, 8'h00, 16'h0000}, 6'h0F, 1'b0);
        buf_mark = 1'b0;
        access({chain_addr, 8'h00, 16'h0000}, 6'h0B, 1'b0);
        access({chain_addr, 8'h01, 16'h0000}, 6'h0B, 1'b0);
        buf_empty = 1'b1;
        access({chain_addr, 8'h00, 16'h0000}, 6'h08, 1'b0);
        chain_last = 1'b0;
        access({chain_addr, 8'h00, 16'h1006}, 6'h09, 1'b1);
        // empty first board hands the token on, stays silent
        chain_first = 1'b1;
        exp_kind = vsad_pkg::VSAD_NONE;
        req = 1'b1;
        req_addr = {chain_addr, 24'h000000};
        req_am = 6'h0B;
        req_write = 1'b0;
        @(negedge clk);
        req = 1'b0;
        repeat (12) @(negedge clk);
        check("token", {31'h0, bus_if.iackout_n}, 32'h0);
        check("hung", {31'h0, busy}, 32'h1);
        do_reset(slot);
        check("reads left", 32'(rd_q.size()), 32'h0);
        summarize();
    end
endmodule : test_vme_slave_address_decode
